// >>> dv/hhra_cpu_model.sv
// Processor model answering host hold with hold acknowledge.
`timescale 1ns/100ps
module hhra_cpu_model (
  // Clock and pace
  input wire logic i_clk,
  input wire logic i_slow,
  // Hold handshake
  input wire logic i_host_hold_request,
  output logic o_host_hold_ack
);
  // ****************
  // Handshake
  // ****************
  logic [3:0] wait_count = 4'h0;
  initial o_host_hold_ack = 1'h0;
  always @(posedge i_clk) begin
    if (!i_host_hold_request) begin
      wait_count <= 4'h0;
      o_host_hold_ack <= 1'h0;
    end else if (wait_count == (i_slow ? 4'h7 : 4'h1)) begin
      o_host_hold_ack <= 1'h1;
    end else begin
      wait_count <= wait_count + 4'h1;
    end
  end
endmodule

// >>> dv/hhra_props.sv
// Port checker for the host hold and refresh arbiter.
`timescale 1ns/100ps
module hhra_props (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Inputs
  input wire logic [7:0] i_cfg_a,
  input wire logic [7:0] i_cfg_b,
  input wire logic i_delayed_hold_request,
  input wire logic i_refresh_request,
  input wire logic i_slowdown_hold_req_n,
  input wire logic i_host_hold_ack,
  input wire logic i_eisa_cycle_active,
  input wire logic i_memctl_ready,
  input wire logic i_power_good,
  // Outputs
  input wire logic o_host_hold_request,
  input wire logic o_refresh_or_hold_ack,
  input wire logic o_host_miss_oe
);
  // ****************
  // Checks
  // ****************
  logic hid;
  assign hid = i_cfg_a[1] && i_cfg_b[1];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_delayed_hold_request;
    i_delayed_hold_request [*3];
  endsequence
  sequence s_ref;
    i_refresh_request [*3];
  endsequence
  sequence s_idle;
    (!i_delayed_hold_request && !i_refresh_request &&
      i_slowdown_hold_req_n) [*5];
  endsequence
  a_hold_on_delayed_hold_request: assert property (
    s_delayed_hold_request |-> ##[0:2] o_host_hold_request) else $error("no hold");
  a_hold_on_slow: assert property (
    (!i_slowdown_hold_req_n) [*3] |-> ##[0:2] o_host_hold_request)
    else $error("no slow hold");
  a_hold_idle_drop: assert property (
    s_idle |-> !o_host_hold_request) else $error("hold stuck");
  a_ack_needs_ready: assert property (
    $rose(o_refresh_or_hold_ack) |-> $past(i_memctl_ready, 3))
    else $error("ack rose while not ready");
  a_ack_after_hlda: assert property (
    $rose(o_refresh_or_hold_ack) && !hid |-> $past(i_host_hold_ack, 3))
    else $error("ack without hold ack");
  a_ack_keeps_hold: assert property (
    s_delayed_hold_request ##0 o_refresh_or_hold_ack |=> o_refresh_or_hold_ack)
    else $error("ack dropped in hold");
  a_ack_keeps_ref: assert property (
    s_ref ##0 (hid && o_refresh_or_hold_ack) |=> o_refresh_or_hold_ack)
    else $error("ack dropped in refresh");
  a_eisa_done_first: assert property (
    $rose(o_refresh_or_hold_ack) && hid && i_refresh_request
      |-> !$past(i_eisa_cycle_active)) else $error("ack during cycle");
  a_miss_pin_floats: assert property (
    (!i_power_good) [*4] |-> !o_host_miss_oe) else $error("pin driven");
endmodule
bind hhra_arbiter hhra_props u_props (.*);

// >>> dv/testbench.sv
// Self-checking bench for the host hold and refresh arbiter.
`timescale 1ns/100ps
module testbench;
  // ****************
  // Bench
  // ****************
  logic i_clk = 1'h0, i_rst = 1'h1, cpu_slow = 1'h0;
  logic [7:0] cfg_a = 8'h00, cfg_b = 8'h00;
  logic delayed_hold_request = 1'h0, refr = 1'h0, slow_n = 1'h1, cpu_bus_request = 1'h0;
  logic act = 1'h0, req = 1'h0, loc_n = 1'h1, rdy = 1'h1;
  logic pg = 1'h1, sw_n = 1'h1, tsel = 1'h0, strap_n = 1'h1;
  logic em_n = 1'h1, im_n = 1'h1, sdrv = 1'h0, ddrv = 1'h0;
  logic pdr = 1'h0, dout = 1'h0;
  logic [3:0] sout = 4'h0;
  wire logic hold, hlda, stall, ack, miss_n, miss_oe, tmode;
  wire logic st_oe, dr_o, dr_oe, dr_in, em, im;
  wire logic [3:0] st_o, st_in;
  wire logic miss_w = miss_oe ? miss_n : strap_n;
  wire logic [3:0] st_w = st_oe ? st_o : 4'ha;
  wire logic dr_w = dr_oe ? dr_o : pdr;
  wire logic [3:0] obs = {hold, ack, stall, miss_n};
  int fails = 0, check_count = 0;
  always #20 i_clk = ~i_clk;
  hhra_arbiter dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'h1),
    .i_cfg_a(cfg_a), .i_cfg_b(cfg_b),
    .i_delayed_hold_request(delayed_hold_request), .i_refresh_request(refr),
    .i_slowdown_hold_req_n(slow_n), .o_host_hold_request(hold),
    .i_host_hold_ack(hlda), .i_cpu_bus_request(cpu_bus_request),
    .i_eisa_cycle_active(act), .i_eisa_cycle_request(req),
    .i_local_device_n(loc_n), .i_coproc_select_n(loc_n),
    .i_local_memory_n(loc_n), .o_eisa_cycle_stall(stall),
    .i_memctl_ready(rdy), .o_refresh_or_hold_ack(ack),
    .i_host_miss_n(miss_w), .o_host_miss_n(miss_n),
    .o_host_miss_oe(miss_oe), .i_power_good(pg),
    .i_reset_switch_n(sw_n), .i_isa_wide_io_test_select(tsel),
    .o_test_mode(tmode), .i_interchip_status(st_w),
    .i_status_out(sout), .i_status_drive(sdrv),
    .o_interchip_status(st_o), .o_interchip_status_oe(st_oe),
    .o_status_in(st_in), .i_delayed_ready(dr_w),
    .i_delayed_ready_out(dout), .i_delayed_ready_drive(ddrv),
    .o_delayed_ready(dr_o), .o_delayed_ready_oe(dr_oe),
    .o_delayed_ready_in(dr_in), .i_eisa_master_active_n(em_n),
    .i_isa_master_active_n(im_n), .o_eisa_master(em),
    .o_isa_master(im));
  hhra_cpu_model cpu (.i_clk(i_clk), .i_slow(cpu_slow),
    .i_host_hold_request(hold), .o_host_hold_ack(hlda));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_ack(input logic v);
    int n;
    n = 0;
    while (ack !== v && n < 40) begin
      cyc(1);
      n++;
    end
    if (ack !== v) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic t_delayed_hold_request();
    delayed_hold_request = 1'h1;
    cyc(5);
    chk(obs, 4'h8);
    wait_ack(1'h1);
    chk(obs, 4'hc);
    cyc(6);
    chk(obs, 4'hc);
    delayed_hold_request = 1'h0;
    wait_ack(1'h0);
    cyc(4);
    chk(obs, 4'h1);
  endtask
  task automatic t_plain(input logic [7:0] a, input logic [7:0] b);
    cfg_a = a;
    cfg_b = b;
    cpu_slow = 1'h1;
    refr = 1'h1;
    cyc(9);
    chk(obs, 4'h8);
    wait_ack(1'h1);
    refr = 1'h0;
    wait_ack(1'h0);
    cpu_slow = 1'h0;
    cyc(4);
  endtask
  task automatic t_hidden();
    cfg_a = 8'h02;
    cfg_b = 8'h02;
    act = 1'h1;
    refr = 1'h1;
    cyc(8);
    chk(obs, 4'h1);
    act = 1'h0;
    wait_ack(1'h1);
    cyc(1);
    chk(obs, 4'h5);
    req = 1'h1;
    loc_n = 1'h0;
    cyc(3);
    chk(obs, 4'h7);
    loc_n = 1'h1;
    cyc(3);
    chk(obs, 4'h6);
    refr = 1'h0;
    wait_ack(1'h0);
    cyc(2);
    chk(obs, 4'h1);
    req = 1'h0;
    rdy = 1'h0;
    refr = 1'h1;
    cyc(10);
    chk(obs, 4'h1);
    rdy = 1'h1;
    wait_ack(1'h1);
    refr = 1'h0;
    wait_ack(1'h0);
  endtask
  task automatic t_misc();
    for (int i = 0; i < 2; i++) begin
      slow_n = 1'h0;
      cyc(5);
      chk(obs, 4'h8);
      slow_n = 1'h1;
      cyc(5);
      chk(obs, 4'h1);
    end
    cpu_bus_request = 1'h1;
    cyc(4);
    chk(obs, 4'h0);
    cpu_bus_request = 1'h0;
    cyc(4);
    chk(obs, 4'h1);
  endtask
  task automatic t_side();
    sdrv = 1'h1;
    sout = 4'h6;
    ddrv = 1'h1;
    dout = 1'h1;
    em_n = 1'h0;
    cyc(4);
    chk(st_o, 4'h6);
    chk(st_in, 4'h6);
    chk({st_oe, dr_oe, em, im}, 4'he);
    chk({dr_o, dr_oe, dr_in, 1'h0}, 4'he);
    sdrv = 1'h0;
    ddrv = 1'h0;
    dout = 1'h0;
    pdr = 1'h1;
    em_n = 1'h1;
    im_n = 1'h0;
    cyc(4);
    chk(st_in, 4'ha);
    chk({st_oe, dr_in, em, im}, 4'h5);
    chk({dr_o, dr_oe, 2'h0}, 4'h0);
  endtask
  task automatic t_strap();
    tsel = 1'h1;
    sw_n = 1'h0;
    cyc(5);
    chk({tmode, miss_oe, 2'h0}, 4'h0);
    sw_n = 1'h1;
    cyc(5);
    chk({tmode, miss_oe, 2'h0}, 4'h4);
    pg = 1'h0;
    strap_n = 1'h0;
    cyc(5);
    chk({tmode, miss_oe, 2'h0}, 4'h0);
    pg = 1'h1;
    cyc(5);
    chk({tmode, miss_oe, 2'h0}, 4'hc);
  endtask
  initial begin
    cyc(6);
    i_rst = 1'h0;
    cyc(4);
    chk(obs, 4'h1);
    t_delayed_hold_request();
    t_plain(8'h00, 8'h00);
    t_plain(8'h02, 8'hfd);
    t_plain(8'hfd, 8'h02);
    t_hidden();
    cfg_a = 8'h00;
    t_misc();
    t_side();
    t_strap();
    report_and_stop();
  end
endmodule

// >>> hdl/hhra_arbiter.sv
// Host hold and refresh arbiter with sideband status and test strap.
`timescale 1ns/100ps
`include "hhra_consts.svh"
module hhra_arbiter #(
  parameter int STATUS_W = `HHRA_STATUS_W
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Hidden refresh enable bits from the two configuration registers
  input wire logic [7:0] i_cfg_a,
  input wire logic [7:0] i_cfg_b,
  // Requests from the system peripheral
  input wire logic i_delayed_hold_request,
  input wire logic i_refresh_request,
  input wire logic i_slowdown_hold_req_n,
  // CPU handshake
  output logic o_host_hold_request,
  input wire logic i_host_hold_ack,
  input wire logic i_cpu_bus_request,
  // Host cycle status
  input wire logic i_eisa_cycle_active,
  input wire logic i_eisa_cycle_request,
  input wire logic i_local_device_n,
  input wire logic i_coproc_select_n,
  input wire logic i_local_memory_n,
  output logic o_eisa_cycle_stall,
  // Memory controller
  input wire logic i_memctl_ready,
  // Acknowledge to peripheral
  output logic o_refresh_or_hold_ack,
  // Shared miss and test-strap pin
  input wire logic i_host_miss_n,
  output logic o_host_miss_n,
  output logic o_host_miss_oe,
  // Power and reset switch
  input wire logic i_power_good,
  input wire logic i_reset_switch_n,
  input wire logic i_isa_wide_io_test_select,
  output logic o_test_mode,
  // Sideband to peripheral
  input wire logic [STATUS_W-1:0] i_interchip_status,
  input wire logic [STATUS_W-1:0] i_status_out,
  input wire logic i_status_drive,
  output logic [STATUS_W-1:0] o_interchip_status,
  output logic o_interchip_status_oe,
  output logic [STATUS_W-1:0] o_status_in,
  input wire logic i_delayed_ready,
  input wire logic i_delayed_ready_out,
  input wire logic i_delayed_ready_drive,
  output logic o_delayed_ready,
  output logic o_delayed_ready_oe,
  output logic o_delayed_ready_in,
  input wire logic i_eisa_master_active_n,
  input wire logic i_isa_master_active_n,
  output logic o_eisa_master,
  output logic o_isa_master
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  logic [STATUS_W-1:0] st_sync;
  logic s_delayed_hold_request;
  logic s_refresh;
  logic s_slow_n;
  logic s_hlda;
  logic s_cpu_bus_request;
  logic s_ready;
  logic s_pgood;
  logic s_rsw_n;
  logic s_tsel;
  logic s_strap_n;

  assign raw = {i_delayed_hold_request, i_refresh_request,
    i_slowdown_hold_req_n, i_host_hold_ack, i_cpu_bus_request,
    i_memctl_ready, i_power_good, i_reset_switch_n,
    i_isa_wide_io_test_select, i_host_miss_n};
  // Each synchroniser but power good and the reset switch, which start low, starts at
  // the idle level of its pin, so that no false hold, miss or strap reading appears in
  // the cycles after reset.
  localparam logic [NSYNC-1:0] RSTV = {`HHRA_ZERO1, `HHRA_ZERO1,
    `HHRA_ONE1, `HHRA_ZERO1,
    `HHRA_ZERO1, `HHRA_ONE1, `HHRA_ZERO1, `HHRA_ZERO1, `HHRA_ZERO1,
    `HHRA_ONE1};
  assign {s_delayed_hold_request, s_refresh, s_slow_n, s_hlda, s_cpu_bus_request, s_ready,
    s_pgood, s_rsw_n, s_tsel, s_strap_n} = syn;

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      hhra_sync #(
        .RESET_VALUE(RSTV[g])
      ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_d(raw[g]),
        .o_q(syn[g])
      );
    end
    for (g = 0; g < STATUS_W; g++) begin : g_st
      hhra_sync u_st (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_d(i_interchip_status[g]),
        .o_q(st_sync[g])
      );
    end
  endgenerate

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    hhra_pkg::hhra_state_type state;
    logic hold;
    logic ack;
    logic miss_n;
    logic miss_oe;
    logic power_ok;
    logic test_mode;
    logic stall;
    logic st_oe;
    logic [STATUS_W-1:0] st_out;
    logic [STATUS_W-1:0] st_in;
    logic dr_oe;
    logic dr_out;
    logic dr_in;
    logic eisa_m;
    logic isa_m;
    logic dr_sync1;
    logic dr_sync2;
    logic em_sync1;
    logic em_sync2;
    logic im_sync1;
    logic im_sync2;
  } hhra_regs_type;

  hhra_regs_type r;
  hhra_regs_type next_r;

  logic hidden_en;
  logic hold_src;
  logic pending_eisa;
  logic power_up;

  assign hidden_en = i_cfg_a[`HHRA_HIDDEN_EN_BIT] &
    i_cfg_b[`HHRA_HIDDEN_EN_BIT];
  assign pending_eisa = i_eisa_cycle_request & i_local_device_n &
    i_coproc_select_n & i_local_memory_n;
  assign power_up = s_pgood & s_rsw_n;

  always_comb begin
    next_r = r;
    hold_src = s_delayed_hold_request | (s_refresh & ~hidden_en) | ~s_slow_n;
    if (i_ce) begin
      next_r.hold = hold_src;
      case (r.state)
        hhra_pkg::HHRA_IDLE: begin
          next_r.ack = `HHRA_ZERO1;
          if (s_delayed_hold_request | (s_refresh & ~hidden_en)) begin
            next_r.state = hhra_pkg::HHRA_HOLD_WAIT;
          end else if (s_refresh & hidden_en & ~i_eisa_cycle_active &
              s_ready) begin
            next_r.state = hhra_pkg::HHRA_HIDDEN;
            next_r.ack = `HHRA_ONE1;
          end
        end
        hhra_pkg::HHRA_HOLD_WAIT: begin
          if (~(s_delayed_hold_request | s_refresh)) begin
            next_r.state = hhra_pkg::HHRA_IDLE;
          end else if (s_hlda & s_ready) begin
            next_r.state = hhra_pkg::HHRA_GRANTED;
            next_r.ack = `HHRA_ONE1;
          end
        end
        hhra_pkg::HHRA_GRANTED: begin
          if (~(s_delayed_hold_request | s_refresh)) begin
            next_r.state = hhra_pkg::HHRA_IDLE;
            next_r.ack = `HHRA_ZERO1;
          end
        end
        hhra_pkg::HHRA_HIDDEN: begin
          if (~s_refresh) begin
            next_r.state = hhra_pkg::HHRA_IDLE;
            next_r.ack = `HHRA_ZERO1;
          end
        end
        default: begin
          next_r.state = hhra_pkg::HHRA_IDLE;
          next_r.ack = `HHRA_ZERO1;
        end
      endcase
      // In hidden refresh every cycle with the EISA cycle request up is held, local ones included;
      // other CPU work runs on beside the refresh.
      // in hidden refresh all EISA cycle requests wait, local too
      next_r.stall = (next_r.state == hhra_pkg::HHRA_HIDDEN) &
        i_eisa_cycle_request;
      // miss on non-local EISA request in hidden refresh, hold or bus request
      next_r.miss_n = ~(((r.state == hhra_pkg::HHRA_HIDDEN) & r.ack &
        pending_eisa) | r.hold | s_cpu_bus_request);
      // The enable lags power by one edge so that the strap is read first.
      // float pin during power or switch low
      next_r.power_ok = power_up;
      next_r.miss_oe = power_up & r.power_ok;
      // The pin is still released on this edge, so the synchronised
      // pin value is the strap and not the miss output.
      // strap caught at leading edge
      if (power_up & ~r.power_ok) begin
        next_r.test_mode = ~s_strap_n & s_tsel;
      end
      next_r.st_oe = i_status_drive;
      next_r.st_out = i_status_out;
      next_r.st_in = st_sync;
      next_r.dr_sync1 = i_delayed_ready;
      next_r.dr_sync2 = r.dr_sync1;
      next_r.dr_in = r.dr_sync2;
      next_r.dr_oe = i_delayed_ready_drive;
      next_r.dr_out = i_delayed_ready_out;
      next_r.em_sync1 = ~i_eisa_master_active_n;
      next_r.em_sync2 = r.em_sync1;
      next_r.eisa_m = r.em_sync2;
      next_r.im_sync1 = ~i_isa_master_active_n;
      next_r.im_sync2 = r.im_sync1;
      next_r.isa_m = r.im_sync2;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '0;
      r.state <= hhra_pkg::HHRA_IDLE;
      r.miss_n <= `HHRA_ONE1;
      r.st_out <= '0;
      r.st_in <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_host_hold_request = r.hold;
  assign o_refresh_or_hold_ack = r.ack;
  assign o_eisa_cycle_stall = r.stall;
  assign o_host_miss_n = r.miss_n;
  assign o_host_miss_oe = r.miss_oe;
  assign o_test_mode = r.test_mode;
  assign o_interchip_status = r.st_out;
  assign o_interchip_status_oe = r.st_oe;
  assign o_status_in = r.st_in;
  assign o_delayed_ready = r.dr_out;
  assign o_delayed_ready_oe = r.dr_oe;
  assign o_delayed_ready_in = r.dr_in;
  assign o_eisa_master = r.eisa_m;
  assign o_isa_master = r.isa_m;
endmodule

// >>> hdl/hhra_consts.svh
// Named constants for the host hold and refresh arbiter.
`ifndef HHRA_CONSTS_SVH
`define HHRA_CONSTS_SVH
`define HHRA_STATUS_W 4
`define HHRA_HIDDEN_EN_BIT 1
`define HHRA_SYNC_STAGES 2
`define HHRA_ZERO1 1'h0
`define HHRA_ONE1 1'h1
`define HHRA_ZERO4 4'h0
`endif

// >>> hdl/hhra_pkg.sv
// Types shared by the host hold and refresh arbiter.
package hhra_pkg;
  typedef enum logic [1:0] {
    HHRA_IDLE = 2'h0,
    HHRA_HOLD_WAIT = 2'h1,
    HHRA_GRANTED = 2'h3,
    HHRA_HIDDEN = 2'h2
  } hhra_state_type;
endpackage

// >>> hdl/hhra_sync.sv
// Two-flop synchroniser for one input from outside the clock domain.
`timescale 1ns/100ps
module hhra_sync #(
  parameter logic RESET_VALUE = 1'h0
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Data
  input wire logic i_d,
  output logic o_q
);
  typedef struct packed {
    logic first;
    logic second;
  } hhra_sync_type;

  hhra_sync_type r;
  hhra_sync_type next_r;

  always_comb begin
    next_r = r;
    if (i_ce) begin
      next_r.first = i_d;
      next_r.second = r.first;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= {RESET_VALUE, RESET_VALUE};
    end else begin
      r <= next_r;
    end
  end

  assign o_q = r.second;
endmodule
